// ---- hdl/cplc_pkg.sv ----
package cplc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses on the 8-bit register port
  localparam logic [7:0] CPLC_ADDR_SYSTEM_POWER_STATE = 8'h00;
  localparam logic [7:0] CPLC_ADDR_PUMP_CONTROL       = 8'hac;
  localparam logic [7:0] CPLC_ADDR_PUMP_TIMING        = 8'had;
  localparam logic [7:0] CPLC_ADDR_PUMP_THRESHOLD     = 8'hae;

  // Field positions
  localparam int CPLC_SYS_ACTIVE_BIT   = 0;
  localparam int CPLC_PUMP_ENABLE_BIT  = 7;
  localparam int CPLC_SAVER_BIT        = 6;
  localparam int CPLC_TRACK_LSB        = 4;
  localparam int CPLC_MANUAL_LSB       = 2;
  localparam int CPLC_DECAY_LSB        = 3;
  localparam int CPLC_CLKDIV_LSB       = 0;
  localparam int CPLC_THRESH_LSB       = 0;

  // Reset values of the fields
  localparam logic       CPLC_RST_SYS_ACTIVE = 1'b0;
  localparam logic       CPLC_RST_PUMP_EN    = 1'b0;
  localparam logic       CPLC_RST_SAVER      = 1'b1;
  localparam logic [1:0] CPLC_RST_TRACK      = 2'h2;
  localparam logic [1:0] CPLC_RST_MANUAL     = 2'h0;
  localparam logic [2:0] CPLC_RST_DECAY      = 3'h2;
  localparam logic [2:0] CPLC_RST_CLKDIV     = 3'h1;
  localparam logic [5:0] CPLC_RST_THRESH     = 6'h0e;

  // Tracking source codes
  localparam logic [1:0] CPLC_TRK_MANUAL = 2'h0;
  localparam logic [1:0] CPLC_TRK_MAXVOL = 2'h1;
  localparam logic [1:0] CPLC_TRK_DACVOL = 2'h2;
  localparam logic [1:0] CPLC_TRK_SIGMAG = 2'h3;

  // Pump level codes
  localparam logic [1:0] CPLC_LVL_STANDBY = 2'h0;
  localparam logic [1:0] CPLC_LVL_HALF    = 2'h2;
  localparam logic [1:0] CPLC_LVL_FULL    = 2'h3;

  // Clock divider codes
  localparam logic [2:0] CPLC_CLK_STOP = 3'h5;

  // Decay times in ms, per code; code 6 is undefined and treated as 512 ms
  localparam int CPLC_CLK_HZ     = 20_000_000;
  localparam int CPLC_CYC_PER_MS = CPLC_CLK_HZ / 1000;
  localparam int CPLC_DECAY_MS_MAX = 512;

  // Control fields travelling together
  typedef struct packed {
    logic       sys_active;
    logic       pump_enable;
    logic       low_load_power_saver;
    logic [1:0] tracking_source_select;
    logic [1:0] manual_level_select;
    logic [2:0] decay_interval_select;
    logic [2:0] pump_clock_divider;
    logic [5:0] half_rail_threshold;
  } cplc_cfg_s;

  // Decay code to ms
  function automatic logic [9:0] cplc_decay_ms(input logic [2:0] code);
    case (code)
      3'h0:    cplc_decay_ms = 10'h000;
      3'h1:    cplc_decay_ms = 10'h002;
      3'h2:    cplc_decay_ms = 10'h004;
      3'h3:    cplc_decay_ms = 10'h010;
      3'h4:    cplc_decay_ms = 10'h040;
      3'h5:    cplc_decay_ms = 10'h080;
      default: cplc_decay_ms = 10'h200;
    endcase
  endfunction : cplc_decay_ms

endpackage : cplc_pkg

// ---- hdl/cplc_top.sv ----
// Summary of operation
// - Pump runs only while pump enable is one; disabled after reset.
// - Low-load power saver bit turns on reduced switching; resets to one.
// - Tracking source picks manual, largest volume, DAC volume or signal magnitude.
// - Manual level picks standby, half or full supply; code 01 reserved.
// - Decay field sets full-to-half transition time, 0 to 512 ms.
// - Clock field divides system clock by 8 to 128, or stops it.
// - Half rail allowed when tracked level is at or below threshold.
// - Threshold compare only used for tracking codes 10 and 11.
// - Device stays in standby until system active bit is set.
`timescale 1ns/1ns
`default_nettype none

module cplc_top
  import cplc_pkg::*;
#(
  parameter int DECAY_CYC_PER_MS = CPLC_CYC_PER_MS
)(
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       srst,
  // Register port
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output var  logic [7:0] reg_rdata_q,
  // Level sources from the audio path
  input  wire logic [5:0] max_out_volume,
  input  wire logic [5:0] dac_volume,
  input  wire logic [5:0] signal_magnitude,
  // Analog pump stage
  output var  logic       system_active_q,
  output var  logic       pump_run_q,
  output var  logic       low_power_mode_q,
  output var  logic [1:0] pump_level_q,
  output var  logic       pump_clock_en_q
);

  initial
  begin
    if (DECAY_CYC_PER_MS < 1 || DECAY_CYC_PER_MS > 1048576)
      $error("DECAY_CYC_PER_MS must be from one to 2**20");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file
  cplc_cfg_s cfg_q, cfg_d;
  logic [7:0] rdata_d;

  // Writes land only in defined fields, reserved bits dropped
  always_comb
  begin
    cfg_d = cfg_q;
    if (reg_wr)
    begin
      case (reg_addr)
        CPLC_ADDR_SYSTEM_POWER_STATE: cfg_d.sys_active = reg_wdata[CPLC_SYS_ACTIVE_BIT];
        CPLC_ADDR_PUMP_CONTROL:
        begin
          cfg_d.pump_enable            = reg_wdata[CPLC_PUMP_ENABLE_BIT];
          cfg_d.low_load_power_saver   = reg_wdata[CPLC_SAVER_BIT];
          cfg_d.tracking_source_select = reg_wdata[CPLC_TRACK_LSB +: 2];
          cfg_d.manual_level_select    = reg_wdata[CPLC_MANUAL_LSB +: 2];
        end
        CPLC_ADDR_PUMP_TIMING:
        begin
          cfg_d.decay_interval_select = reg_wdata[CPLC_DECAY_LSB +: 3];
          cfg_d.pump_clock_divider    = reg_wdata[CPLC_CLKDIV_LSB +: 3];
        end
        CPLC_ADDR_PUMP_THRESHOLD: cfg_d.half_rail_threshold = reg_wdata[CPLC_THRESH_LSB +: 6];
        default: ;
      endcase
    end
  end

  // Read mux, reserved bits as zero, unmapped reads zero
  always_comb
  begin
    rdata_d = 8'h00;
    case (reg_addr)
      CPLC_ADDR_SYSTEM_POWER_STATE: rdata_d[CPLC_SYS_ACTIVE_BIT] = cfg_q.sys_active;
      CPLC_ADDR_PUMP_CONTROL:
      begin
        rdata_d[CPLC_PUMP_ENABLE_BIT]   = cfg_q.pump_enable;
        rdata_d[CPLC_SAVER_BIT]         = cfg_q.low_load_power_saver;
        rdata_d[CPLC_TRACK_LSB +: 2]    = cfg_q.tracking_source_select;
        rdata_d[CPLC_MANUAL_LSB +: 2]   = cfg_q.manual_level_select;
      end
      CPLC_ADDR_PUMP_TIMING:
      begin
        rdata_d[CPLC_DECAY_LSB +: 3]  = cfg_q.decay_interval_select;
        rdata_d[CPLC_CLKDIV_LSB +: 3] = cfg_q.pump_clock_divider;
      end
      CPLC_ADDR_PUMP_THRESHOLD: rdata_d[CPLC_THRESH_LSB +: 6] = cfg_q.half_rail_threshold;
      default: ;
    endcase
  end

  // Register the fields and read data
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      cfg_q.sys_active             <= CPLC_RST_SYS_ACTIVE;
      cfg_q.pump_enable            <= CPLC_RST_PUMP_EN;
      cfg_q.low_load_power_saver   <= CPLC_RST_SAVER;
      cfg_q.tracking_source_select <= CPLC_RST_TRACK;
      cfg_q.manual_level_select    <= CPLC_RST_MANUAL;
      cfg_q.decay_interval_select  <= CPLC_RST_DECAY;
      cfg_q.pump_clock_divider     <= CPLC_RST_CLKDIV;
      cfg_q.half_rail_threshold    <= CPLC_RST_THRESH;
      reg_rdata_q                  <= 8'h00;
    end
    else
    begin
      cfg_q       <= cfg_d;
      reg_rdata_q <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Level selection and decay
  typedef enum logic [1:0] {
    CPLC_ST_FULL  = 2'b01,
    CPLC_ST_DECAY = 2'b10
  } cplc_state_e;

  cplc_state_e st_q, st_d;
  logic [5:0]  tracked;
  logic        want_half;
  logic        want_full;
  logic [1:0]  level_d;
  logic [19:0] ms_cnt_q, ms_cnt_d;
  logic [9:0]  ms_left_q, ms_left_d;
  logic        running;

  assign running = cfg_q.sys_active && cfg_q.pump_enable;

  // Tracked level from the chosen source
  always_comb
  begin
    case (cfg_q.tracking_source_select)
      CPLC_TRK_MAXVOL: tracked = max_out_volume;
      CPLC_TRK_DACVOL: tracked = dac_volume;
      CPLC_TRK_SIGMAG: tracked = signal_magnitude;
      default:         tracked = 6'h00;
    endcase
    // Automatic codes compare against threshold; code 01 always runs full
    want_half = 1'b0;
    want_full = 1'b0;
    if (cfg_q.tracking_source_select == CPLC_TRK_MANUAL)
    begin
      want_half = cfg_q.manual_level_select == CPLC_LVL_HALF;
      want_full = cfg_q.manual_level_select == CPLC_LVL_FULL;
    end
    else if (cfg_q.tracking_source_select == CPLC_TRK_MAXVOL)
      want_full = 1'b1;
    else
    begin
      want_half = tracked <= cfg_q.half_rail_threshold;
      want_full = !want_half;
    end
  end

  // Full-to-half steps wait the decay interval before dropping
  always_comb
  begin
    st_d      = st_q;
    ms_cnt_d  = ms_cnt_q;
    ms_left_d = ms_left_q;
    level_d   = CPLC_LVL_STANDBY;
    if (!running || !(want_half || want_full))
      st_d = CPLC_ST_FULL;
    else
    begin
      case (st_q)
        CPLC_ST_FULL:
        begin
          level_d = want_half ? CPLC_LVL_HALF : CPLC_LVL_FULL;
          if (pump_level_q == CPLC_LVL_FULL && want_half
              && cplc_decay_ms(cfg_q.decay_interval_select) != 10'h000)
          begin
            st_d      = CPLC_ST_DECAY;
            level_d   = CPLC_LVL_FULL;
            ms_cnt_d  = 20'h00000;
            ms_left_d = cplc_decay_ms(cfg_q.decay_interval_select);
          end
        end
        CPLC_ST_DECAY:
        begin
          level_d = CPLC_LVL_FULL;
          if (want_full)
            st_d = CPLC_ST_FULL;
          else if (ms_cnt_q == 20'(DECAY_CYC_PER_MS - 1))
          begin
            ms_cnt_d  = 20'h00000;
            ms_left_d = ms_left_q - 10'h001;
            if (ms_left_q == 10'h001)
            begin
              st_d    = CPLC_ST_FULL;
              level_d = CPLC_LVL_HALF;
            end
          end
          else
            ms_cnt_d = ms_cnt_q + 20'h00001;
        end
        default: st_d = CPLC_ST_FULL;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pump clock divider, one-cycle enable pulse
  logic [6:0] div_q, div_d;
  logic       clk_en_d;

  always_comb
  begin
    div_d    = div_q + 7'h01;
    clk_en_d = 1'b0;
    if (!running || cfg_q.pump_clock_divider > 3'h4) // Stop and reserved codes
      div_d = 7'h00;
    else if (div_q == 7'((8 << cfg_q.pump_clock_divider) - 1))
    begin
      div_d    = 7'h00;
      clk_en_d = 1'b1;
    end
  end

  // State and output registers
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      st_q             <= CPLC_ST_FULL;
      ms_cnt_q         <= 20'h00000;
      ms_left_q        <= 10'h000;
      div_q            <= 7'h00;
      system_active_q  <= 1'b0;
      pump_run_q       <= 1'b0;
      low_power_mode_q <= 1'b0;
      pump_level_q     <= CPLC_LVL_STANDBY;
      pump_clock_en_q  <= 1'b0;
    end
    else
    begin
      st_q             <= st_d;
      ms_cnt_q         <= ms_cnt_d;
      ms_left_q        <= ms_left_d;
      div_q            <= div_d;
      system_active_q  <= cfg_q.sys_active;
      pump_run_q       <= running;
      low_power_mode_q <= running && cfg_q.low_load_power_saver;
      pump_level_q     <= level_d;
      pump_clock_en_q  <= clk_en_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_pump_off;
    !pump_run_q;
  endsequence

  property p_pump_off;
    @(posedge clock) disable iff (srst) !cfg_q.pump_enable |=> s_pump_off;
  endproperty
  a_pump_off: assert property (p_pump_off) else $error("pump runs while disabled");

  property p_saver;
    @(posedge clock) disable iff (srst) running |=> low_power_mode_q == $past(cfg_q.low_load_power_saver);
  endproperty
  a_saver: assert property (p_saver) else $error("power saver mismatch");

  property p_manual_full;
    @(posedge clock) disable iff (srst)
      running && cfg_q.tracking_source_select == CPLC_TRK_MANUAL && cfg_q.manual_level_select == CPLC_LVL_FULL
      |=> pump_level_q == CPLC_LVL_FULL;
  endproperty
  a_manual_full: assert property (p_manual_full) else $error("manual full not applied");

  property p_manual_standby;
    @(posedge clock) disable iff (srst)
      cfg_q.tracking_source_select == CPLC_TRK_MANUAL && cfg_q.manual_level_select == CPLC_LVL_STANDBY
      |=> pump_level_q == CPLC_LVL_STANDBY;
  endproperty
  a_manual_standby: assert property (p_manual_standby) else $error("manual standby not applied");

  property p_maxvol_full;
    @(posedge clock) disable iff (srst)
      running && cfg_q.tracking_source_select == CPLC_TRK_MAXVOL |=> pump_level_q == CPLC_LVL_FULL;
  endproperty
  a_maxvol_full: assert property (p_maxvol_full) else $error("threshold used on code 01");

  property p_above_full;
    @(posedge clock) disable iff (srst)
      running && cfg_q.tracking_source_select[1] && !want_half |=> pump_level_q == CPLC_LVL_FULL;
  endproperty
  a_above_full: assert property (p_above_full) else $error("half rail above threshold");

  property p_decay_hold;
    @(posedge clock) disable iff (srst)
      st_q == CPLC_ST_FULL && st_d == CPLC_ST_DECAY && cfg_q.decay_interval_select == 3'h1 && want_half
      |=> pump_level_q == CPLC_LVL_FULL;
  endproperty
  a_decay_hold: assert property (p_decay_hold) else $error("decay skipped");

  property p_clk_stop;
    @(posedge clock) disable iff (srst)
      cfg_q.pump_clock_divider == CPLC_CLK_STOP [*2] |=> !pump_clock_en_q;
  endproperty
  a_clk_stop: assert property (p_clk_stop) else $error("pump clock runs when stopped");

  property p_standby;
    @(posedge clock) disable iff (srst) !cfg_q.sys_active |=> !pump_run_q && !system_active_q;
  endproperty
  a_standby: assert property (p_standby) else $error("active in standby");

  property p_readback;
    @(posedge clock) disable iff (srst)
      !reg_wr && reg_addr == CPLC_ADDR_PUMP_THRESHOLD |=> reg_rdata_q == {2'b00, $past(cfg_q.half_rail_threshold)};
  endproperty
  a_readback: assert property (p_readback) else $error("threshold readback wrong");

endmodule : cplc_top

`default_nettype wire

// ---- tb/cplc_top_tb.sv ----
`timescale 1ns/1ns
`default_nettype none

module cplc_top_tb;
  import cplc_pkg::*;

  localparam int CPM = 4;
  logic       clock;
  logic       srst;
  logic       reg_wr;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata_q;
  logic [5:0] max_out_volume;
  logic [5:0] dac_volume;
  logic [5:0] signal_magnitude;
  logic       system_active_q;
  logic       pump_run_q;
  logic       low_power_mode_q;
  logic [1:0] pump_level_q;
  logic       pump_clock_en_q;
  int         err_total = 0;
  int         tests_run = 0;
  int         cyc       = 0;
  logic [7:0] addr_tbl [5] = '{8'h00, 8'hac, 8'had, 8'hae, 8'h55};
  logic [7:0] mask_tbl [5] = '{8'h01, 8'hfc, 8'h3f, 8'h3f, 8'h00};
  logic [7:0] rst_tbl  [5] = '{8'h00, 8'h60, 8'h11, 8'h0e, 8'h00};
  logic [5:0] th;
  int         i;

  cplc_top #(.DECAY_CYC_PER_MS(CPM)) cplc_top_inst (
    .clock(clock), .srst(srst), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata_q(reg_rdata_q), .max_out_volume(max_out_volume), .dac_volume(dac_volume),
    .signal_magnitude(signal_magnitude), .system_active_q(system_active_q), .pump_run_q(pump_run_q),
    .low_power_mode_q(low_power_mode_q), .pump_level_q(pump_level_q), .pump_clock_en_q(pump_clock_en_q));

  ////////////////////////////////////////////////////////////////////////////
  // Free-running 50 ns clock
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // Hang guard, far above the longest decay wait
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      err_total++;
      summarize();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : summarize

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : chk

  // One write, strobe dropped at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr    <= 1'b0;
  endtask : wr

  // Read data is registered one edge after the address
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    reg_addr <= a;
    @(posedge clock);
    #1;
    chk(reg_rdata_q, e);
  endtask : rd

  // Outputs packed as {0,active,run,saver,level}; settle two edges first
  task automatic st(input logic [7:0] e);
    repeat (2) @(posedge clock);
    #1;
    chk({3'h0, system_active_q, pump_run_q, low_power_mode_q, pump_level_q}, e);
  endtask : st

  task automatic src(input logic [5:0] mx, input logic [5:0] dv, input logic [5:0] sm);
    @(posedge clock);
    max_out_volume   <= mx;
    dac_volume       <= dv;
    signal_magnitude <= sm;
  endtask : src

  function automatic int dec_ms(input logic [2:0] c);
    int t [8] = '{0, 2, 4, 16, 64, 128, 512, 512};
    return t[c];
  endfunction : dec_ms

  // Pump clock period per divider code; no pulses for stop and reserved codes
  task automatic clk_chk(input logic [2:0] c, input bit on);
    int gap;
    int k;
    int t;
    gap = 0;
    k   = 0;
    t   = 0;
    wr(8'had, {5'h00, c});
    repeat (3) @(posedge clock);
    while (k < 2 && t < 600)
    begin
      @(posedge clock);
      #1;
      t++;
      if (k == 1)
        gap++;
      if (pump_clock_en_q === 1'b1)
        k++;
    end
    chk(8'(k), (on && c <= 3'h4) ? 8'h02 : 8'h00);
    chk(8'(gap), (on && c <= 3'h4) ? 8'(8 << c) : 8'h00);
  endtask : clk_chk

  // Full rail holds for the decay time, then drops to half
  task automatic decay_chk(input logic [2:0] c);
    int w;
    w = dec_ms(c) * CPM;
    wr(8'had, {2'h0, c, 3'h1});
    src(6'h00, 6'h00, 6'h3f);
    st(8'h1f);
    src(6'h00, 6'h00, 6'h00);
    if (w > 0)
    begin
      repeat (w - 2) @(posedge clock);
      #1;
      chk({6'h00, pump_level_q}, 8'h03);
    end
    repeat (6) @(posedge clock);
    #1;
    chk({6'h00, pump_level_q}, 8'h02);
  endtask : decay_chk

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    srst = 1'b1;
    reg_wr = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    max_out_volume = 6'h00;
    dac_volume = 6'h00;
    signal_magnitude = 6'h00;
    void'($urandom(32'h2893a4ad));
    repeat (3) @(posedge clock);
    srst <= 1'b0;
    st(8'h00);
    for (i = 0; i < 5; i++)
      rd(addr_tbl[i], rst_tbl[i]);
    // Random writes, reserved bits and unmapped place read back as zero
    for (i = 0; i < 24; i++)
    begin
      automatic int j = $urandom_range(4, 0);
      automatic logic [7:0] d = 8'($urandom());
      if (i < 5)
        j = i;
      if (i < 5)
        d = 8'hff;
      wr(addr_tbl[j], d);
      rd(addr_tbl[j], d & mask_tbl[j]);
    end
    // Standby overrides an enabled pump
    wr(8'h00, 8'h00);
    wr(8'had, 8'h01);
    wr(8'hac, 8'hcc);
    st(8'h00);
    wr(8'h00, 8'h01);
    for (i = 0; i < 4; i++)
    begin
      wr(8'hac, 8'hc0 | 8'(i << 2));
      st({6'h07, (i == 1) ? 2'h0 : 2'(i)});
    end
    wr(8'hac, 8'h8c);
    st(8'h1b);
    wr(8'hac, 8'h4c);
    st(8'h10);
    clk_chk(3'h1, 1'b0);
    wr(8'hac, 8'hcc);
    for (i = 0; i < 8; i++)
      clk_chk(3'(i), 1'b1);
    // Largest-volume tracking ignores the threshold
    wr(8'had, 8'h01);
    wr(8'hac, 8'hd0);
    src(6'h00, 6'h3f, 6'h3f);
    st(8'h1f);
    // Threshold boundary on the dac and magnitude sources
    for (i = 0; i < 8; i++)
    begin
      th = 6'($urandom_range(62, 1));
      if (i == 0)
        th = 6'h00;
      wr(8'hae, {2'h0, th});
      wr(8'hac, (i[0]) ? 8'hf0 : 8'he0);
      src(6'h3f, i[0] ? 6'h3f : th, i[0] ? th : 6'h3f);
      st(8'h1e);
      src(6'h00, i[0] ? 6'h00 : th + 6'h01, i[0] ? th + 6'h01 : 6'h00);
      st(8'h1f);
    end
    wr(8'hae, 8'h0e);
    wr(8'hac, 8'hf0);
    for (i = 0; i < 8; i++)
      decay_chk(3'(i));
    // Reset again in mid-run
    @(posedge clock);
    srst <= 1'b1;
    @(posedge clock);
    srst <= 1'b0;
    rd(8'hac, 8'h60);
    st(8'h00);
    summarize();
  end

endmodule : cplc_top_tb

`default_nettype wire
